// [logic/pwmog_core.sv]
`timescale 1ns/100ps
`include "pwmog_map.svh"

module pwmog_core
	import pwmog_pkg::*;
#(
	parameter int CLK_KHZ = `PWMOG_CLK_KHZ
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_wr,
	input  wire logic        mem_rd,
	input  wire pwmog_byte_t mem_wdata,
	output pwmog_byte_t      mem_rdata,
	output logic             mem_hit,
	output logic             pwm_out
);
	// Period is 2^16 sub-steps of one tick; top rate = clk/(BASE_DIV*65536)
	// 64-bit sums: the clock in hundredths of a hertz does not fit a 32-bit int
	localparam longint CLK_X100 = longint'(CLK_KHZ) * 64'h186A0;
	localparam longint TOP_X100 = longint'(`PWMOG_FMAX_HZ_X100) * 64'h10000;
	localparam int BASE_DIV = int'((CLK_X100 + TOP_X100 - 64'h1) / TOP_X100);
	localparam int BASE_DIV_SAFE = (BASE_DIV < 1) ? 1 : BASE_DIV;

	pwmog_byte_t  freq_q, freq_d;
	pwmog_byte_t  wlo_q, wlo_d;
	pwmog_byte_t  whi_q, whi_d;
	pwmog_byte_t  rdata_q, rdata_d;
	pwmog_width_t phase_q, phase_d;
	logic         out_q, out_d;
	logic         enable;
	logic         tick;
	pwmog_width_t width;

	// ************************************************************
	// Register file
	// ************************************************************
	// Byte writes at the documented addresses; reads are registered
	always_comb begin
		freq_d  = freq_q;
		wlo_d   = wlo_q;
		whi_d   = whi_q;
		rdata_d = rdata_q;
		if (mem_wr) begin
			unique case (mem_addr)
				`PWMOG_ADDR_FREQ_CTRL:  freq_d = mem_wdata;
				`PWMOG_ADDR_WIDTH_LOW:  wlo_d  = mem_wdata;
				`PWMOG_ADDR_WIDTH_HIGH: whi_d  = mem_wdata;
				default: ;
			endcase
		end
		if (mem_rd) begin
			unique case (mem_addr)
				`PWMOG_ADDR_FREQ_CTRL:  rdata_d = freq_q;
				`PWMOG_ADDR_WIDTH_LOW:  rdata_d = wlo_q;
				`PWMOG_ADDR_WIDTH_HIGH: rdata_d = whi_q;
				default:                rdata_d = `PWMOG_RESET_BYTE;
			endcase
		end
	end

	// All fields clear on reset
	always_ff @(posedge clk) begin
		if (rst) begin
			freq_q  <= `PWMOG_RESET_BYTE;
			wlo_q   <= `PWMOG_RESET_BYTE;
			whi_q   <= `PWMOG_RESET_BYTE;
			rdata_q <= `PWMOG_RESET_BYTE;
		end else begin
			freq_q  <= freq_d;
			wlo_q   <= wlo_d;
			whi_q   <= whi_d;
			rdata_q <= rdata_d;
		end
	end

	assign mem_rdata = rdata_q;
	assign mem_hit   = (mem_addr == `PWMOG_ADDR_FREQ_CTRL) ||
	                   (mem_addr == `PWMOG_ADDR_WIDTH_LOW) ||
	                   (mem_addr == `PWMOG_ADDR_WIDTH_HIGH);
	assign enable    = freq_q[`PWMOG_EN_BIT];
	assign width     = {whi_q, wlo_q};

	// ************************************************************
	// Frequency tick
	// ************************************************************
	pwmog_prescaler #(
		.BASE_DIV (BASE_DIV_SAFE)
	) u_presc (
		.clk  (clk),
		.rst  (rst),
		.run  (enable),
		.code (freq_q[`PWMOG_CODE_MSB:0]),
		.tick (tick)
	);

	// ************************************************************
	// Period counter and comparator
	// ************************************************************
	// Full scale forced high so FFFFh has no one-step low glitch per period
	always_comb begin
		phase_d = phase_q;
		out_d   = 1'b0;
		if (!enable) begin
			phase_d = `PWMOG_WIDTH_ZERO;
			out_d   = 1'b0;
		end else begin
			if (tick)
				phase_d = phase_q + 16'h0001;
			// Current phase, so the first step after enable lasts a full tick
			if (width == `PWMOG_WIDTH_FULL)
				out_d = 1'b1;
			else
				out_d = (phase_q < width);
		end
	end

	// Output from a flip-flop to avoid comparator glitches on the pin
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_q <= `PWMOG_WIDTH_ZERO;
			out_q   <= 1'b0;
		end else begin
			phase_q <= phase_d;
			out_q   <= out_d;
		end
	end

	assign pwm_out = out_q;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_disabled;
		!enable;
	endsequence

	a_disabled_low: assert property (@(posedge clk) disable iff (rst)
		s_disabled |=> !pwm_out) else $error("pwm output high while disabled");
	a_counter_idle: assert property (@(posedge clk) disable iff (rst)
		s_disabled |=> (phase_q == `PWMOG_WIDTH_ZERO))
		else $error("period counter moved while disabled");
	a_zero_low: assert property (@(posedge clk) disable iff (rst)
		(width == `PWMOG_WIDTH_ZERO) |=> !pwm_out) else $error("zero width drove output high");
	a_full_high: assert property (@(posedge clk) disable iff (rst)
		(enable && width == `PWMOG_WIDTH_FULL) |=> pwm_out)
		else $error("full width not constant high");
	a_low_write: assert property (@(posedge clk) disable iff (rst)
		(mem_wr && mem_addr == `PWMOG_ADDR_WIDTH_LOW) |=> (width[7:0] == $past(mem_wdata)))
		else $error("low byte write lost");
	a_high_write: assert property (@(posedge clk) disable iff (rst)
		(mem_wr && mem_addr == `PWMOG_ADDR_WIDTH_HIGH) |=> (width[15:8] == $past(mem_wdata)))
		else $error("high byte write lost");
	a_tick_steps: assert property (@(posedge clk) disable iff (rst)
		(enable && tick) |=> (phase_q == $past(phase_q) + 16'h0001))
		else $error("phase did not advance on tick");
	a_hold_notick: assert property (@(posedge clk) disable iff (rst)
		(enable && !tick) ##1 enable |-> (phase_q == $past(phase_q)))
		else $error("phase moved without tick");

	// ************************************************************
	// Register bus checks
	// ************************************************************
	// One access of the given kind at the given address
	sequence s_rd_at(logic [15:0] addr);
		mem_rd && (mem_addr == addr);
	endsequence
	sequence s_wr_at(logic [15:0] addr);
		mem_wr && (mem_addr == addr);
	endsequence

	// Reads return the register as it stood at the read edge, even beside a write
	a_read_freq: assert property (@(posedge clk) disable iff (rst)
		s_rd_at(`PWMOG_ADDR_FREQ_CTRL) |=> (mem_rdata == $past(freq_q)))
		else $error("frequency register read wrong");
	a_read_low: assert property (@(posedge clk) disable iff (rst)
		s_rd_at(`PWMOG_ADDR_WIDTH_LOW) |=> (mem_rdata == $past(wlo_q)))
		else $error("low byte read wrong");
	a_read_high: assert property (@(posedge clk) disable iff (rst)
		s_rd_at(`PWMOG_ADDR_WIDTH_HIGH) |=> (mem_rdata == $past(whi_q)))
		else $error("high byte read wrong");
	// Read data stand until the next read, so a late sample is still good
	a_rdata_holds: assert property (@(posedge clk) disable iff (rst)
		!mem_rd |=> $stable(mem_rdata))
		else $error("read data changed without a read");
	// Writes land in the addressed register and nowhere else
	a_freq_write: assert property (@(posedge clk) disable iff (rst)
		s_wr_at(`PWMOG_ADDR_FREQ_CTRL) |=> (freq_q == $past(mem_wdata)))
		else $error("frequency write lost");
	a_stray_write: assert property (@(posedge clk) disable iff (rst)
		(mem_wr && !mem_hit) |=> ($stable(freq_q) && $stable(width)))
		else $error("unmapped write changed a register");

	// ************************************************************
	// Output checks
	// ************************************************************
	// Enable goes from off to on
	sequence s_enable_rise;
		!enable ##1 enable;
	endsequence

	// First enabled cycle starts at phase zero, pin set by the width alone
	a_first_phase: assert property (@(posedge clk) disable iff (rst)
		s_enable_rise |-> (phase_q == `PWMOG_WIDTH_ZERO))
		else $error("phase not zero when enabled");
	a_first_step: assert property (@(posedge clk) disable iff (rst)
		s_enable_rise |=> (pwm_out == ($past(width) != `PWMOG_WIDTH_ZERO)))
		else $error("first pin level wrong");
	// Below full scale the pin is high exactly while the phase is under the width
	a_duty_follow: assert property (@(posedge clk) disable iff (rst)
		(enable && (width != `PWMOG_WIDTH_FULL)) |=> (pwm_out == ($past(phase_q) < $past(width))))
		else $error("pin does not follow width");
	// A nonzero code leaves at least one idle clock between ticks
	a_tick_spaced: assert property (@(posedge clk) disable iff (rst)
		(enable && tick && (freq_q[`PWMOG_CODE_MSB:0] != 7'h00)) ##1 $stable(freq_q) |-> !tick)
		else $error("ticks closer than the code allows");
endmodule

// [logic/pwmog_map.svh]
`ifndef PWMOG_MAP_SVH
`define PWMOG_MAP_SVH

// ************************************************************
// Register addresses on the MCU data space
// ************************************************************
`define PWMOG_ADDR_WIDTH_HIGH   16'hFFBD
`define PWMOG_ADDR_WIDTH_LOW    16'hFFBE
`define PWMOG_ADDR_FREQ_CTRL    16'hFFBF

// ************************************************************
// Field layout and reset values
// ************************************************************
`define PWMOG_EN_BIT            7
`define PWMOG_CODE_MSB          6
`define PWMOG_RESET_BYTE        8'h00
`define PWMOG_WIDTH_ZERO        16'h0000
`define PWMOG_WIDTH_FULL        16'hFFFF

// ************************************************************
// Timing
// ************************************************************
`define PWMOG_CLK_KHZ           250000
`define PWMOG_FMAX_HZ_X100      9375000

`endif

// [logic/pwmog_pkg.sv]
package pwmog_pkg;
	typedef logic [7:0]  pwmog_byte_t;
	typedef logic [15:0] pwmog_width_t;
	typedef logic [6:0]  pwmog_code_t;
endpackage

// [logic/pwmog_prescaler.sv]
`timescale 1ns/100ps
`include "pwmog_map.svh"

// Tick generator: one tick every (code+1)*BASE_DIV clocks, idle while disabled
module pwmog_prescaler
	import pwmog_pkg::*;
#(
	parameter int BASE_DIV = 1
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire pwmog_code_t code,
	output logic             tick
);
	localparam int CW = 16;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] limit;

	// ************************************************************
	// Count
	// ************************************************************
	// Larger code means lower output frequency
	always_comb begin
		limit = CW'((32'(code) + 32'd1) * 32'(BASE_DIV) - 32'd1);
		cnt_d = cnt_q;
		if (!run)
			cnt_d = '0;
		else if (cnt_q >= limit)
			cnt_d = '0;
		else
			cnt_d = cnt_q + CW'(1);
	end

	// Registered state
	always_ff @(posedge clk) begin
		if (rst)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	assign tick = run && (cnt_q >= limit);
endmodule

// [sim/pwmog_load.sv]
`timescale 1ns/100ps
// ********
// Load model on the pin: integrates high time
// ********
module pwmog_load (
	input  wire logic   clk,
	input  wire logic   clear,
	input  wire logic   pwm_in,
	output int unsigned high_cnt
);
	// Counts high cycles; a cycle count stands in for the filter's charge
	always_ff @(posedge clk) begin
		if (clear)
			high_cnt <= 0;
		else if (pwm_in)
			high_cnt <= high_cnt + 1;
	end
endmodule

// [sim/pwm_output_generator_tb.sv]
`timescale 1ns/100ps
`include "pwmog_map.svh"
// ********
// Bench: register accesses and pin measurements
// ********
module pwm_output_generator_tb;
	import pwmog_pkg::*;
	localparam logic [15:0] a_hi = `PWMOG_ADDR_WIDTH_HIGH;
	localparam logic [15:0] a_lo = `PWMOG_ADDR_WIDTH_LOW;
	localparam logic [15:0] a_fq = `PWMOG_ADDR_FREQ_CTRL;
	logic        clk = 0, rst = 1, mem_wr = 0, mem_rd = 0, clear = 1;
	logic [15:0] mem_addr = 16'h0000;
	pwmog_byte_t mem_wdata = 8'h00, mem_rdata;
	logic        mem_hit, pwm_out;
	int unsigned high_cnt, fails = 0, compares = 0, cycles = 0;
	pwmog_code_t codes [4] = '{7'h00, 7'h01, 7'h02, 7'h7F};
	always #2 clk = ~clk;
	pwmog_core u_pwmog_core (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_wr(mem_wr),
		.mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit),
		.pwm_out(pwm_out));
	pwmog_load u_pwmog_load (.clk(clk), .clear(clear), .pwm_in(pwm_out), .high_cnt(high_cnt));
	// Single exit point for both the normal end and a hang
	task complete_run;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// Strobes are one-cycle pulses, launched on the falling edge
	task wr(input logic [15:0] a, input pwmog_byte_t d);
		@(negedge clk) {mem_addr, mem_wdata, mem_wr} = {a, d, 1'b1};
		@(negedge clk) mem_wr = 0;
	endtask
	task rd(input logic [15:0] a, input pwmog_byte_t e);
		@(negedge clk) {mem_addr, mem_rd} = {a, 1'b1};
		@(negedge clk) mem_rd = 0;
		chk(mem_rdata === e, "read data");
	endtask
	// Total high time of one pulse; window is wider than the longest pulse tried
	task pulse(input pwmog_width_t w, input pwmog_code_t c, input int unsigned exp);
		wr(a_fq, 8'h00);
		wr(a_hi, w[15:8]);
		wr(a_lo, w[7:0]);
		clear = 1;
		wr(a_fq, {1'b1, c});
		clear = 0;
		repeat (500) @(negedge clk);
		chk(high_cnt == exp, "pulse high time");
	endtask
	// Hang guard, about two and a half times the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			complete_run;
		end
	end
	initial begin
		repeat (12) @(negedge clk);
		rst = 0;
		rd(a_hi, `PWMOG_RESET_BYTE);
		rd(a_lo, `PWMOG_RESET_BYTE);
		rd(a_fq, `PWMOG_RESET_BYTE);
		wr(a_lo, 8'hA5);
		wr(a_hi, 8'h3C);
		wr(a_fq, 8'h15);
		rd(a_lo, 8'hA5);
		rd(a_hi, 8'h3C);
		rd(a_fq, 8'h15);
		chk(mem_hit === 1'b1, "no hit on mapped");
		rd(16'hFFBC, 8'h00);
		chk(mem_hit === 1'b0, "hit on unmapped");
		repeat (20) begin
			@(negedge clk);
			chk(pwm_out === 1'b0, "pin while disabled");
		end
		wr(a_hi, 8'hFF);
		wr(a_lo, 8'hFF);
		wr(a_fq, 8'h80);
		repeat (3) @(negedge clk);
		repeat (8) begin
			@(negedge clk);
			chk(pwm_out === 1'b1, "full scale high");
		end
		wr(a_fq, 8'h00);
		@(negedge clk);
		chk(pwm_out === 1'b0, "low after disable");
		// Reset in mid-run with the output running must clear everything
		wr(a_fq, 8'h85);
		@(negedge clk);
		chk(pwm_out === 1'b1, "pin before reset");
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		chk(pwm_out === 1'b0, "pin after reset");
		rd(a_hi, `PWMOG_RESET_BYTE);
		rd(a_fq, `PWMOG_RESET_BYTE);
		foreach (codes[i]) pulse(16'h0003, codes[i], 3 * (codes[i] + 1));
		pulse(`PWMOG_WIDTH_ZERO, 7'h00, 0);
		pulse(16'h0100, 7'h00, 256);
		complete_run;
	end
endmodule
